/* File: hdl/crr_readout.sv */
// Conversion result readout, serial frame output and data-ready pin control
// Function
// - Idle-command response frame carries both precision results
// - Auxiliary results stored from address 10h upward
// - One register read returns up to 32 registers
// - Selected precision completion lowers data-ready
// - Already low: high pulse before new fall
// - Data-ready rises after second result shifted out
// - Early chip-select rise keeps data-ready low
// - Repeated reads return same results; counters distinguish
// - Completion during read buffered, loaded next frame
// - Buffered result keeps data-ready low after read
// - Unread buffered result replaced by newer one
// - Conversion start write raises data-ready
// - After restart, old results stay readable
// - Only register section 0 decoded by address; other sections invalid
// - Invalid address reads return zero data, address
`default_nettype none
module crr_readout (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic data_ready_n_o,
    input wire logic ready_source_select_i,
    input wire logic conversion_start_bit_i,
    input wire logic precision_adc_a_done_i,
    input wire logic [crr_pkg::RESULT_W-1:0] precision_adc_a_data_i,
    input wire logic precision_adc_b_done_i,
    input wire logic [crr_pkg::RESULT_W-1:0] precision_adc_b_data_i,
    input wire logic aux_valid_i,
    input wire logic [crr_pkg::AUX_IDX_W-1:0] aux_addr_i,
    input wire logic [crr_pkg::REG_W-1:0] aux_data_i,
    output logic aux_ready_o
);
    import crr_pkg::*;

    function automatic crr_section_t section_of(input logic [ADDR_W-1:0] a);
        section_of = crr_section_t'(a[7:6]);
    endfunction : section_of

    function automatic logic reg_valid(input logic [ADDR_W-1:0] a);
        reg_valid = (section_of(a) == SEC_STATUS) && (a <= ADDR_SECTION0_LAST) &&
                    ((a <= ADDR_CLOCK_FLAGS) || (a >= ADDR_AUX_BASE && a <= ADDR_AUX_LAST));
    endfunction : reg_valid

    // Core-domain synchronisers for chip select and link events
    logic cs_meta, cs_sync, cs_last;
    logic bt_meta, bt_sync, bt_last;
    logic ct_meta, ct_sync, ct_last;
    logic b_tgl, cmd_tgl;
    logic [CMD_W-1:0] cmd_word;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_last <= 1'b1;
            bt_meta <= 1'b0;
            bt_sync <= 1'b0;
            bt_last <= 1'b0;
            ct_meta <= 1'b0;
            ct_sync <= 1'b0;
            ct_last <= 1'b0;
        end else begin
            cs_meta <= cs_n_i;
            cs_sync <= cs_meta;
            cs_last <= cs_sync;
            bt_meta <= b_tgl;
            bt_sync <= bt_meta;
            bt_last <= bt_sync;
            ct_meta <= cmd_tgl;
            ct_sync <= ct_meta;
            ct_last <= ct_sync;
        end
    end

    wire frame_active = !cs_sync;
    wire frame_end = cs_sync && !cs_last;
    wire b_evt = bt_sync ^ bt_last;
    wire cmd_evt = ct_sync ^ ct_last;

    // Precision result holding: output image, pending buffer, counters
    logic [1:0] done;
    logic [RESULT_W-1:0] new_data [2];
    logic [RESULT_W-1:0] out_res [2];
    logic [RESULT_W-1:0] buf_res [2];
    logic [1:0] buf_valid;
    logic [CONV_CNT_W-1:0] conv_cnt [2];

    assign done = {precision_adc_b_done_i, precision_adc_a_done_i};
    assign new_data[0] = precision_adc_a_data_i;
    assign new_data[1] = precision_adc_b_data_i;

    for (genvar i = 0; i < 2; i++) begin : g_conv
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                out_res[i] <= '0;
                buf_res[i] <= '0;
                buf_valid[i] <= 1'b0;
                conv_cnt[i] <= '0;
            end else if (done[i]) begin
                conv_cnt[i] <= conv_cnt[i] + 1'b1;
                if (frame_active) begin
                    buf_res[i] <= new_data[i];
                    buf_valid[i] <= 1'b1;
                end else begin
                    out_res[i] <= new_data[i];
                    buf_valid[i] <= 1'b0;
                end
            end else if (frame_end && buf_valid[i]) begin
                out_res[i] <= buf_res[i];
                buf_valid[i] <= 1'b0;
            end
        end
    end

    // Data-ready pin state machine
    crr_ready_state_t st, next_st;
    logic [PULSE_CNT_W-1:0] pulse_cnt, next_pulse;
    wire sel_done = ready_source_select_i ? done[1] : done[0];
    wire sel_buf = ready_source_select_i ? buf_valid[1] : buf_valid[0];

    always_comb begin
        next_st = st;
        next_pulse = '0;
        case (st)
            READY_HIGH: begin
                if (sel_done) next_st = READY_LOW;
            end
            READY_LOW: begin
                if (sel_done) next_st = READY_PULSE;
                else if (conversion_start_bit_i) next_st = READY_HIGH;
                else if (b_evt && !sel_buf) next_st = READY_HIGH;
            end
            READY_PULSE: begin
                next_pulse = pulse_cnt + 1'b1;
                if (conversion_start_bit_i) next_st = READY_HIGH;
                else if (pulse_cnt == PULSE_LAST) next_st = READY_LOW;
            end
            default: next_st = READY_HIGH;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= READY_HIGH;
            pulse_cnt <= '0;
            data_ready_n_o <= 1'b1;
        end else begin
            st <= next_st;
            pulse_cnt <= next_pulse;
            data_ready_n_o <= next_st != READY_LOW;
        end
    end

    // Register read requests; the following frame is assumed to be idle
    logic stage_v, register_read_command_pend;
    logic [ADDR_W-1:0] stage_addr, register_read_command_addr;
    logic [CMD_CNT_W-1:0] stage_cnt, register_read_command_cnt;
    wire is_register_read_command = cmd_word[CMD_W-1:CMD_OP_LSB] == REGISTER_READ_COMMAND_OPCODE;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_v <= 1'b0;
            stage_addr <= '0;
            stage_cnt <= '0;
            register_read_command_pend <= 1'b0;
            register_read_command_addr <= '0;
            register_read_command_cnt <= '0;
        end else begin
            if (cmd_evt) begin
                stage_v <= is_register_read_command;
                stage_addr <= cmd_word[CMD_ADDR_LSB +: ADDR_W];
                stage_cnt <= cmd_word[CMD_CNT_W-1:0];
            end else if (frame_end) begin
                stage_v <= 1'b0;
            end
            if (frame_end) begin
                register_read_command_pend <= stage_v && !cmd_evt;
                register_read_command_addr <= stage_addr;
                register_read_command_cnt <= stage_cnt;
            end
        end
    end

    // Auxiliary results drain from the FIFO; stalled while a register read frame is pending
    crr_stream_if #(.W(AUX_W)) aux_in ();
    crr_stream_if #(.W(AUX_W)) aux_out ();
    logic [REG_W-1:0] aux_mem [AUX_DEPTH];

    assign aux_in.valid = aux_valid_i;
    assign aux_in.data = {aux_addr_i, aux_data_i};
    assign aux_ready_o = aux_in.ready;
    assign aux_out.ready = !register_read_command_pend;

    crr_fifo #(.W(AUX_W), .D(FIFO_DEPTH)) u_aux_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_s(aux_in),
        .out_s(aux_out)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < AUX_DEPTH; k++) aux_mem[k] <= '0;
        end else if (aux_out.valid && aux_out.ready) begin
            aux_mem[aux_out.data[AUX_W-1:REG_W]] <= aux_out.data[REG_W-1:0];
        end
    end

    // Link side: word selection reads core state held still during frames, except the conversion counters, which step on every completion
    logic [4:0] bit_pos;
    logic [WORD_IDX_W-1:0] word_idx;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_sh;
    // Chip select high clears the link counters, so a cut frame restarts cleanly
    wire frame_rst = rst_i || cs_n_i;
    wire [WORD_IDX_W-1:0] reg_ofs = word_idx - 1'b1;
    wire [ADDR_W-1:0] rd_addr = register_read_command_addr + ADDR_W'(reg_ofs);
    wire rd_hit = register_read_command_pend && (word_idx != '0) && (reg_ofs <= WORD_IDX_W'(register_read_command_cnt));
    wire rd_ok = rd_hit && reg_valid(rd_addr);
    wire [AUX_IDX_W-1:0] aux_idx = AUX_IDX_W'(rd_addr - ADDR_AUX_BASE);
    wire [REG_W-1:0] stat_lower = STATUS_LOWER_RST |
                                  (REG_W'({conv_cnt[0], conv_cnt[1]}) << CONV_CNT_LSB);
    wire [REG_W-1:0] reg_val =
        (rd_addr == ADDR_DEVICE_ID) ? DEVICE_ID_VALUE :
        (rd_addr == ADDR_STATUS_UPPER) ? STATUS_UPPER_RST :
        (rd_addr == ADDR_STATUS_LOWER) ? stat_lower :
        (rd_addr == ADDR_SUPPLY_FLAGS) ? SUPPLY_FLAGS_RST :
        (rd_addr == ADDR_CLOCK_FLAGS) ? CLOCK_FLAGS_RST : aux_mem[aux_idx];
    wire [WORD_BITS-1:0] reg_word = rd_ok ? {reg_val, rd_addr} : '0;
    wire [WORD_BITS-1:0] cur_word =
        (word_idx == '0) ? {STATUS_UPPER_RST, ADDR_STATUS_UPPER} :
        register_read_command_pend ? reg_word :
        (word_idx == WORD_RESULT_A) ? out_res[0] :
        (word_idx == WORD_RESULT_B) ? out_res[1] : '0;
    wire word_end = bit_pos == WORD_LAST_BIT;
    wire [WORD_BITS-1:0] rx_next = {rx_sh[WORD_BITS-2:0], sdi_i};

    always_ff @(posedge link_sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            bit_pos <= '0;
            word_idx <= '0;
            tx_sh <= '0;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_oe_o <= 1'b1;
            if (bit_pos == '0) begin
                sdo_o <= cur_word[WORD_BITS-1];
                tx_sh <= {cur_word[WORD_BITS-2:0], 1'b0};
            end else begin
                sdo_o <= tx_sh[WORD_BITS-1];
                tx_sh <= {tx_sh[WORD_BITS-2:0], 1'b0};
            end
            bit_pos <= word_end ? '0 : bit_pos + 1'b1;
            if (word_end && word_idx != WORD_IDX_MAX) word_idx <= word_idx + 1'b1;
        end
    end

    // Events toward the core survive the frame, so only the block reset clears them
    always_ff @(posedge link_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_sh <= '0;
            cmd_word <= '0;
            cmd_tgl <= 1'b0;
            b_tgl <= 1'b0;
        end else begin
            rx_sh <= rx_next;
            if (!cs_n_i && word_end && word_idx == '0) begin
                cmd_word <= rx_next[WORD_BITS-1 -: CMD_W];
                cmd_tgl <= !cmd_tgl;
            end
            if (!cs_n_i && word_end && word_idx == WORD_RESULT_B && !register_read_command_pend) begin
                b_tgl <= !b_tgl;
            end
        end
    end

    // Checks on the core domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ready_falls_done: assert property (st == READY_HIGH && sel_done |=> !data_ready_n_o)
        else $error("data-ready did not fall on completion");
    a_pulse_high_width: assert property (st == READY_LOW && sel_done |=> data_ready_n_o [*5])
        else $error("data-ready high pulse too short");
    a_pulse_then_low: assert property (st == READY_PULSE && pulse_cnt == PULSE_LAST &&
        !conversion_start_bit_i |=> !data_ready_n_o)
        else $error("data-ready did not fall after pulse");
    a_rise_after_b: assert property (st == READY_LOW && b_evt && !sel_buf && !sel_done
        |=> data_ready_n_o)
        else $error("data-ready did not rise after result read");
    a_low_held: assert property (st == READY_LOW && !b_evt && !sel_done && !conversion_start_bit_i
        |=> !data_ready_n_o)
        else $error("data-ready rose without complete read");
    a_buffered_stays_low: assert property (st == READY_LOW && b_evt && sel_buf && !sel_done &&
        !conversion_start_bit_i |=> !data_ready_n_o)
        else $error("data-ready rose with pending result");
    a_buffer_loads: assert property (frame_end && buf_valid[0] && !done[0]
        |=> out_res[0] == $past(buf_res[0]) && !buf_valid[0])
        else $error("buffered result not loaded at frame end");
    a_buffer_replace: assert property (frame_active && done[1]
        |=> buf_res[1] == $past(precision_adc_b_data_i) && buf_valid[1])
        else $error("buffered result not replaced");
    a_start_raises: assert property (conversion_start_bit_i && !sel_done |=> data_ready_n_o)
        else $error("start did not raise data-ready");
    a_results_held: assert property (!done[0] && !frame_end |=> $stable(out_res[0]))
        else $error("result changed without completion");
    a_counter_step: assert property (done[1] |=> conv_cnt[1] == $past(conv_cnt[1]) + 2'h1)
        else $error("conversion counter did not step");

    // Result path of converter a, idle ready state, start during the high pulse and the auxiliary store
    a_counter_step_a: assert property (done[0] |=> conv_cnt[0] == $past(conv_cnt[0]) + 2'h1)
        else $error("conversion counter a did not step");
    a_idle_load_a: assert property (done[0] && !frame_active
        |=> out_res[0] == $past(precision_adc_a_data_i) && !buf_valid[0])
        else $error("idle completion not loaded");
    a_read_hold_a: assert property (done[0] && frame_active
        |=> buf_res[0] == $past(precision_adc_a_data_i) && buf_valid[0] && $stable(out_res[0]))
        else $error("result changed during read");
    a_high_stays_idle: assert property (st == READY_HIGH && !sel_done |=> data_ready_n_o)
        else $error("data-ready fell without selected completion");
    a_start_in_pulse: assert property (st == READY_PULSE && conversion_start_bit_i
        |=> data_ready_n_o)
        else $error("data-ready fell after start in pulse");
    a_aux_stored: assert property (aux_out.valid && aux_out.ready
        |=> aux_mem[$past(aux_out.data[AUX_W-1:REG_W])] == $past(aux_out.data[REG_W-1:0]))
        else $error("auxiliary result not stored");

    c_full_read: cover property (st == READY_LOW && b_evt && !sel_buf);
    c_buffered_read: cover property (frame_active && done[0] && buf_valid[0]);
    c_ready_pulse: cover property (st == READY_PULSE && pulse_cnt == PULSE_LAST);
    c_reg_read_frame: cover property (register_read_command_pend && frame_active);
    c_start_abort: cover property (st == READY_LOW && conversion_start_bit_i && !sel_done);
endmodule : crr_readout
`default_nettype wire

/* File: hdl/crr_pkg.sv */
// Constants and types shared by the conversion readout and ready logic
`default_nettype none
package crr_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int READY_HIGH_PULSE_WIDTH_NS = 100;
    localparam int READY_PULSE_CYC = (READY_HIGH_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 3;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(READY_PULSE_CYC - 1);

    localparam int WORD_BITS = 24;
    localparam logic [4:0] WORD_LAST_BIT = 5'h17;
    localparam int WORD_IDX_W = 6;
    localparam logic [WORD_IDX_W-1:0] WORD_IDX_MAX = 6'h3f;
    localparam logic [WORD_IDX_W-1:0] WORD_RESULT_A = 6'h01;
    localparam logic [WORD_IDX_W-1:0] WORD_RESULT_B = 6'h02;
    localparam int RESULT_W = 24;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int CMD_W = 16;
    localparam int AUX_IDX_W = 5;
    localparam int AUX_W = AUX_IDX_W + REG_W;
    localparam int AUX_DEPTH = 32;
    localparam int FIFO_DEPTH = 8;

    localparam logic [2:0] REGISTER_READ_COMMAND_OPCODE = 3'h5;
    localparam int CMD_OP_LSB = 13;
    localparam int CMD_ADDR_LSB = 5;
    localparam int CMD_CNT_W = 5;

    localparam logic [ADDR_W-1:0] ADDR_DEVICE_ID = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_UPPER = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_LOWER = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_SUPPLY_FLAGS = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_AUX_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_AUX_LAST = 8'h2f;
    localparam logic [ADDR_W-1:0] ADDR_SECTION0_LAST = 8'h2f;

    // Arbitrary identification value
    localparam logic [REG_W-1:0] DEVICE_ID_VALUE = 16'h0a5a;
    localparam logic [REG_W-1:0] STATUS_UPPER_RST = 16'h7fc8;
    localparam logic [REG_W-1:0] STATUS_LOWER_RST = 16'h0000;
    localparam logic [REG_W-1:0] SUPPLY_FLAGS_RST = 16'hffff;
    localparam logic [REG_W-1:0] CLOCK_FLAGS_RST = 16'hfc07;
    localparam int CONV_CNT_W = 2;
    localparam int CONV_CNT_LSB = 8;

    typedef enum logic [1:0] {
        READY_HIGH = 2'b00,
        READY_LOW = 2'b01,
        READY_PULSE = 2'b10
    } crr_ready_state_t;

    typedef enum logic [1:0] {
        SEC_STATUS = 2'b00,
        SEC_GLOBAL = 2'b01,
        SEC_SIDE_A = 2'b10,
        SEC_SIDE_B = 2'b11
    } crr_section_t;
endpackage : crr_pkg
`default_nettype wire

/* File: hdl/crr_stream_if.sv */
// Valid/ready word stream between the block's own modules
`default_nettype none
interface crr_stream_if #(parameter int W = 21) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface : crr_stream_if
`default_nettype wire

/* File: hdl/crr_fifo.sv */
// Parameterised FIFO with registered flags between two stream ports
`default_nettype none
module crr_fifo #(
    parameter int W = 21,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    crr_stream_if.sink in_s,
    crr_stream_if.source out_s
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);

    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
    wire push = in_s.valid && in_ready;
    wire pop = out_valid && out_s.ready;
    wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
    wire [PW-1:0] next_wr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
    wire [PW-1:0] next_rd = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;

    assign in_s.ready = in_ready;
    assign out_s.valid = out_valid;
    assign out_s.data = mem[rd_ptr];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= next_count != FULL_CNT;
            out_valid <= next_count != '0;
            if (push) wr_ptr <= next_wr;
            if (pop) rd_ptr <= next_rd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) mem[wr_ptr] <= in_s.data;
    end
endmodule : crr_fifo
`default_nettype wire

/* File: tb/crr_host_model.sv */
// Serial host model that runs whole frames against the readout block
`default_nettype none
module crr_host_model (
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] rx_word [0:39];

    // Settled after time zero so the link counters see a clearing edge on chip select
    initial begin
        sclk_o <= 1'b0;
        cs_n_o <= 1'b1;
        sdi_o <= 1'b1;
    end

    // Clock stands low between frames; released data line toggles so it never looks held
    task automatic frame(input logic [15:0] cmd, input int nbits);
        logic [23:0] tx;
        tx = {cmd, 8'h00};
        #7 cs_n_o = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            sdi_o = (i < 24) ? tx[23 - i] : 1'b0;
            #16 sclk_o = 1'b1;
            #16 sclk_o = 1'b0;
            rx_word[i / 24] = {rx_word[i / 24][22:0], sdo_oe_i ? sdo_i : 1'bx};
        end
        #16 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #200;
    endtask : frame
endmodule : crr_host_model
`default_nettype wire

/* File: tb/conversion_readout_ready_logic_bench.sv */
// Self-checking bench for the conversion readout and ready logic
`default_nettype none
module conversion_readout_ready_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import crr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic sel = 1'b0;
    logic start = 1'b0;
    logic done_a = 1'b0;
    logic done_b = 1'b0;
    logic [23:0] data_a = 24'h0;
    logic [23:0] data_b = 24'h0;
    logic aux_valid = 1'b0;
    logic [4:0] aux_addr = 5'h0;
    logic [15:0] aux_data = 16'h0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, ready_n, aux_ready;
    logic [23:0] exp_a = 24'h0;
    logic [23:0] exp_b = 24'h0;
    logic [1:0] cnt_a = 2'h0;
    logic [1:0] cnt_b = 2'h0;
    logic [15:0] aux_mem [0:31];
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end

    crr_readout DUT (.clk_i(clk_i), .rst_i(rst_i), .link_sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .data_ready_n_o(ready_n), .ready_source_select_i(sel),
        .conversion_start_bit_i(start), .precision_adc_a_done_i(done_a), .precision_adc_a_data_i(data_a),
        .precision_adc_b_done_i(done_b), .precision_adc_b_data_i(data_b), .aux_valid_i(aux_valid),
        .aux_addr_i(aux_addr), .aux_data_i(aux_data), .aux_ready_o(aux_ready));

    crr_host_model host (.sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
        n_compared++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, want);
        end
    endtask : chk

    function automatic logic [23:0] exp_reg(input logic [7:0] a);
        case (a)
            8'h00: return {DEVICE_ID_VALUE, a};
            8'h01: return {STATUS_UPPER_RST, a};
            8'h02: return {4'h0, cnt_a, cnt_b, 8'h00, a};
            8'h03: return {SUPPLY_FLAGS_RST, a};
            8'h04: return {CLOCK_FLAGS_RST, a};
            default: return (a >= 8'h10 && a <= 8'h2f) ? {aux_mem[a - 8'h10], a} : 24'h0;
        endcase
    endfunction : exp_reg

    // One-cycle completion pulse; returns just after the edge that samples it
    task automatic conv(input logic a, input logic b, input logic [23:0] va, input logic [23:0] vb);
        @(posedge clk_i);
        done_a <= a;
        done_b <= b;
        data_a <= va;
        data_b <= vb;
        @(posedge clk_i);
        done_a <= 1'b0;
        done_b <= 1'b0;
        exp_a = a ? va : exp_a;
        exp_b = b ? vb : exp_b;
        cnt_a += 2'(a);
        cnt_b += 2'(b);
        #1;
    endtask : conv

    task automatic rd_conv(input int nbits, input logic rdy);
        host.frame(16'h0000, nbits);
        chk(host.rx_word[0], {STATUS_UPPER_RST, 8'h01}, "response word");
        chk(host.rx_word[1], exp_a, "result a");
        if (nbits >= 72) chk(host.rx_word[2], exp_b, "result b");
        chk({23'h0, ready_n}, {23'h0, rdy}, "ready after read");
        chk({23'h0, sdo_oe}, 24'h0, "output enable idle");
    endtask : rd_conv

    task automatic rd_regs(input logic [7:0] addr, input logic [4:0] n);
        host.frame(16'h0000, 24 * (n + 2));
        for (int i = 0; i <= n; i++) begin
            chk(host.rx_word[i + 1], exp_reg(addr + 8'(i)), "register word");
        end
    endtask : rd_regs

    task automatic register_read_command(input logic [7:0] addr, input logic [4:0] n);
        host.frame({REGISTER_READ_COMMAND_OPCODE, addr, n}, 24);
        rd_regs(addr, n);
    endtask : register_read_command

    task automatic t_ready();
        int cnt;
        conv(1'b1, 1'b1, 24'h1a0001, 24'h1b0001);
        chk({23'h0, ready_n}, 24'h0, "ready low");
        conv(1'b1, 1'b1, 24'h1a0002, 24'h1b0002);
        cnt = 0;
        while (ready_n === 1'b1 && cnt < 20) begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
        chk(24'(cnt), 24'(READY_PULSE_CYC), "high pulse width");
        rd_conv(71, 1'b0);
        rd_conv(72, 1'b1);
        rd_conv(72, 1'b1);
    endtask : t_ready

    // Two completions land during the frame that reads result n
    task automatic t_buffer();
        conv(1'b1, 1'b1, 24'h1a0003, 24'h1b0003);
        fork
            host.frame(16'h0000, 72);
            begin
                repeat (20) @(posedge clk_i);
                conv(1'b1, 1'b1, 24'h1a0004, 24'h1b0004);
                repeat (20) @(posedge clk_i);
                conv(1'b1, 1'b1, 24'h1a0005, 24'h1b0005);
            end
        join
        chk(host.rx_word[1], 24'h1a0003, "result n a");
        chk(host.rx_word[2], 24'h1b0003, "result n b");
        chk({23'h0, ready_n}, 24'h0, "ready kept low");
        rd_conv(72, 1'b1);
    endtask : t_buffer

    task automatic t_start();
        conv(1'b1, 1'b1, 24'h1a0006, 24'h1b0006);
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        #1;
        chk({23'h0, ready_n}, 24'h1, "ready after start");
        rd_conv(72, 1'b1);
        @(posedge clk_i);
        sel <= 1'b1;
        conv(1'b1, 1'b0, 24'h1a0007, exp_b);
        chk({23'h0, ready_n}, 24'h1, "unselected converter");
        conv(1'b0, 1'b1, exp_a, 24'h1b0007);
        chk({23'h0, ready_n}, 24'h0, "selected converter");
        rd_conv(72, 1'b1);
        conv(1'b0, 1'b1, exp_a, 24'h1b0008);
        conv(1'b0, 1'b1, exp_a, 24'h1b0009);
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
        chk({23'h0, ready_n}, 24'h1, "start during pulse");
    endtask : t_start

    // Fill the staging buffer while a pending read stalls it, then drain
    task automatic t_aux();
        int k;
        host.frame({REGISTER_READ_COMMAND_OPCODE, 8'h10, 5'h1f}, 24);
        k = 0;
        @(posedge clk_i);
        aux_valid <= 1'b1;
        aux_addr <= 5'h0;
        aux_data <= 16'h5a00;
        #1;
        while (aux_ready === 1'b1 && k < 20) begin
            @(posedge clk_i);
            k++;
            aux_addr <= 5'(k);
            aux_data <= 16'h5a00 + 16'(k);
            #1;
        end
        @(posedge clk_i);
        aux_valid <= 1'b0;
        chk(24'(k >= FIFO_DEPTH), 24'h1, "buffer refused");
        rd_regs(8'h10, 5'h1f);
        for (int i = 0; i < k; i++) aux_mem[i] = 16'h5a00 + 16'(i);
        repeat (30) @(posedge clk_i);
        #1;
        chk({23'h0, aux_ready}, 24'h1, "buffer drained");
        @(posedge clk_i);
        aux_valid <= 1'b1;
        aux_addr <= 5'h1f;
        aux_data <= 16'hbeef;
        @(posedge clk_i);
        aux_valid <= 1'b0;
        aux_mem[31] = 16'hbeef;
        register_read_command(8'h10, 5'h1f);
    endtask : t_aux

    initial begin
        // Raised after time zero so every asynchronous clear sees an edge
        rst_i <= 1'b1;
        for (int i = 0; i < 32; i++) aux_mem[i] = 16'h0000;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({22'h0, ready_n, aux_ready}, 24'h3, "reset outputs");
        register_read_command(8'h00, 5'h05);
        register_read_command(8'h7e, 5'h01);
        t_ready();
        t_buffer();
        t_start();
        t_aux();
        register_read_command(8'h02, 5'h00);
        test_done();
    end
endmodule : conversion_readout_ready_logic_bench
`default_nettype wire
